/* verilog/pfc_pkg.sv */
package pfc_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam int unsigned PFC_NREG = 19;
    localparam logic [13:0] PFC_IDX_OD0  = 14'h3F50;
    localparam logic [13:0] PFC_IDX_OD1  = 14'h3F51;
    localparam logic [13:0] PFC_IDX_OD2  = 14'h3F52;
    localparam logic [13:0] PFC_IDX_OD3  = 14'h3F53;
    localparam logic [13:0] PFC_IDX_OD4  = 14'h3F54;
    localparam logic [13:0] PFC_IDX_OD5  = 14'h3F55;
    localparam logic [13:0] PFC_IDX_OD6  = 14'h3F56;
    localparam logic [13:0] PFC_IDX_DS0  = 14'h3EC0;
    localparam logic [13:0] PFC_IDX_DS2  = 14'h3EC1;
    localparam logic [13:0] PFC_IDX_DS3  = 14'h3EC2;
    localparam logic [13:0] PFC_IDX_DS4  = 14'h3EC3;
    localparam logic [13:0] PFC_IDX_DS5  = 14'h3EC4;
    localparam logic [13:0] PFC_IDX_DS6  = 14'h3EC5;
    localparam logic [13:0] PFC_IDX_DS7  = 14'h3EC6;
    localparam logic [13:0] PFC_IDX_STOE = 14'h3F2C;
    localparam logic [13:0] PFC_IDX_STSL = 14'h3F2D;
    localparam logic [13:0] PFC_IDX_LTOE = 14'h3F2E;
    localparam logic [13:0] PFC_IDX_LTSL = 14'h3F2F;
    localparam logic [13:0] PFC_IDX_CLK  = 14'h3F3E;

    // ------------------------------------------------------------------
    // Writable bit masks, reset value and table order
    // ------------------------------------------------------------------
    localparam logic [7:0] PFC_MSK_OD0  = 8'hB0;
    localparam logic [7:0] PFC_MSK_OD1  = 8'h20;
    localparam logic [7:0] PFC_MSK_OD2  = 8'h38;
    localparam logic [7:0] PFC_MSK_OD3  = 8'hC7;
    localparam logic [7:0] PFC_MSK_OD4  = 8'hDD;
    localparam logic [7:0] PFC_MSK_OD5  = 8'h1D;
    localparam logic [7:0] PFC_MSK_OD6  = 8'hE0;
    localparam logic [7:0] PFC_MSK_FULL = 8'hFF;
    localparam logic [7:0] PFC_MSK_DS2  = 8'h7F;
    localparam logic [7:0] PFC_MSK_ST   = 8'h3F;
    localparam logic [7:0] PFC_MSK_LTOE = 8'h07;
    localparam logic [7:0] PFC_MSK_LTSL = 8'h3F;
    localparam logic [7:0] PFC_MSK_CLK  = 8'h0F;
    localparam logic [7:0] PFC_RST_VAL  = 8'h00;

    localparam logic [13:0] PFC_IDX_TAB [PFC_NREG] = '{
        PFC_IDX_OD0, PFC_IDX_OD1, PFC_IDX_OD2, PFC_IDX_OD3, PFC_IDX_OD4,
        PFC_IDX_OD5, PFC_IDX_OD6, PFC_IDX_DS0, PFC_IDX_DS2, PFC_IDX_DS3,
        PFC_IDX_DS4, PFC_IDX_DS5, PFC_IDX_DS6, PFC_IDX_DS7, PFC_IDX_STOE,
        PFC_IDX_STSL, PFC_IDX_LTOE, PFC_IDX_LTSL, PFC_IDX_CLK};
    localparam logic [7:0] PFC_MSK_TAB [PFC_NREG] = '{
        PFC_MSK_OD0, PFC_MSK_OD1, PFC_MSK_OD2, PFC_MSK_OD3, PFC_MSK_OD4,
        PFC_MSK_OD5, PFC_MSK_OD6, PFC_MSK_FULL, PFC_MSK_DS2, PFC_MSK_FULL,
        PFC_MSK_FULL, PFC_MSK_FULL, PFC_MSK_FULL, PFC_MSK_FULL, PFC_MSK_ST,
        PFC_MSK_ST, PFC_MSK_LTOE, PFC_MSK_LTSL, PFC_MSK_CLK};

    // Table slots of the registers that steer logic.
    localparam int unsigned PFC_K_DS0  = 7;
    localparam int unsigned PFC_K_STOE = 14;
    localparam int unsigned PFC_K_STSL = 15;
    localparam int unsigned PFC_K_LTOE = 16;
    localparam int unsigned PFC_K_LTSL = 17;
    localparam int unsigned PFC_K_CLK  = 18;

    // ------------------------------------------------------------------
    // Clock output field and encodings
    // ------------------------------------------------------------------
    localparam int unsigned PFC_CLK_SRC_LSB = 2;
    localparam int unsigned PFC_CLK_PIN_BIT = 1;
    localparam int unsigned PFC_CLK_EN_BIT  = 0;

    typedef enum logic [1:0] {
        PFC_SRC_SUB  = 2'b00,
        PFC_SRC_HS   = 2'b01,
        PFC_SRC_SYS  = 2'b10,
        PFC_SRC_RTC  = 2'b11
    } pfc_clk_src_t;

    typedef enum logic [1:0] {
        PFC_PIN_FIRST  = 2'b00,
        PFC_PIN_SECOND = 2'b01,
        PFC_PIN_THIRD  = 2'b10,
        PFC_PIN_BAD    = 2'b11
    } pfc_pin_code_t;

    // Pin grants of every routed function, at most one per shared pin.
    typedef struct packed {
        logic [5:0] stm_a;
        logic [5:0] stm_b;
        logic [2:0] ltm_a;
        logic [2:0] ltm_b;
        logic [2:0] ltm_c;
        logic       clk_a;
        logic       clk_b;
    } pfc_route_t;

endpackage : pfc_pkg

/* verilog/pfc_top.sv */
// Operation
// - Open-drain bit clear gives push-pull, set gives N-channel open-drain.
// - Port 0 open-drain register writable only at bits 7, 5 and 4.
// - Port 1 open-drain register writable only at bit 5.
// - Port 2 open-drain register writable at bits 5 to 3.
// - Port 3 open-drain register writable at bits 7-6 and 2-0.
// - Port 4 open-drain register writable at bits 7-6, 4-2 and 0.
// - Port 5 open-drain register writable at bits 4-2 and 0.
// - Port 6 open-drain register writable at bits 7-5 only.
// - Drive bit clear asks normal N-channel drive, set asks large drive.
// - Drive registers for ports 0, 2-7 consecutive; port 2 bit 7 zero.
// - Short timer enable bits 5-0 give timer output on pin; 7-6 zero.
// - Short timer select bits pick first pin when clear, second when set.
// - Long timer enable bits 2-0 for timers 9-7; bits 7-3 read zero.
// - Long timer two-bit fields pick first, second or third pin.
// - Clock source field picks sub, high-speed, system or time-base clock.
// - Clock pin bit picks first pin when clear, second when set.
// - Clock enable bit clear keeps general I/O, set gives clock output.
module pfc_top (
    input  wire logic                    clk_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    psel_i,
    input  wire logic                    penable_i,
    input  wire logic                    pwrite_i,
    input  wire logic [15:0]             paddr_i,
    input  wire logic [31:0]             pwdata_i,
    input  wire logic [3:0]              pstrb_i,
    output logic      [31:0]             prdata_o,
    output logic                         pready_o,
    output logic                         pslverr_o,
    input  wire logic                    sub_clk_i,
    input  wire logic                    hs_clk_i,
    input  wire logic                    system_clock_i,
    input  wire logic                    rtc_tb_clk_i,
    output logic      [6:0][7:0]         opendrain_select_bits_o,
    output logic      [7:0][7:0]         drive_strength_bits_o,
    output pfc_pkg::pfc_route_t          route_o,
    output logic                         clock_out_o
);

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [7:0]          regs_reg [pfc_pkg::PFC_NREG];
    logic [pfc_pkg::PFC_NREG-1:0] hit;
    logic                mapped;
    logic [7:0]          rd_next;
    logic                wr_done;
    logic                rd_step;
    pfc_pkg::pfc_route_t route_next;
    pfc_pkg::pfc_route_t route_reg;
    logic                clock_out_reg;
    logic                clock_out_next;
    logic [7:0]          prdata_reg;
    logic                pready_reg;
    logic                pslverr_reg;

    // The access phase waits one cycle so that read data and the error
    // flag can be registered; the write lands when pready is seen high.
    assign rd_step = psel_i & penable_i & ~pready_reg;
    assign wr_done = psel_i & penable_i & pready_reg & pwrite_i;

    always_comb begin
        rd_next = 8'h00;
        for (int k = 0; k < pfc_pkg::PFC_NREG; k++) begin
            if (hit[k]) begin
                rd_next = regs_reg[k];
            end
        end
    end

    assign mapped = |hit;

    genvar g;
    generate
        for (g = 0; g < pfc_pkg::PFC_NREG; g++) begin : g_reg
            assign hit[g] = (paddr_i[15:2] == pfc_pkg::PFC_IDX_TAB[g]) &
                            (paddr_i[1:0] == 2'h0);
            // Masking the stored value keeps absent bits at zero.
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    regs_reg[g] <= pfc_pkg::PFC_RST_VAL;
                end else if (wr_done & hit[g] & pstrb_i[0]) begin
                    regs_reg[g] <= pwdata_i[7:0] &
                                   pfc_pkg::PFC_MSK_TAB[g];
                end
            end
            reserved_zero_a: assert property (
                @(posedge clk_i) disable iff (!rst_n_i)
                (regs_reg[g] & ~pfc_pkg::PFC_MSK_TAB[g]) == 8'h00)
                else $error("Reserved register bit holds a one.");
        end
    endgenerate

    // ------------------------------------------------------------------
    // APB slave answer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 8'h00;
        end else if (rd_step) begin
            pready_reg  <= 1'b1;
            pslverr_reg <= ~mapped;
            prdata_reg  <= pwrite_i ? 8'h00 : rd_next;
        end else begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 8'h00;
        end
    end

    assign prdata_o  = {24'h00_0000, prdata_reg};
    assign pready_o  = pready_reg;
    assign pslverr_o = pslverr_reg;

    // ------------------------------------------------------------------
    // Pad controls
    // ------------------------------------------------------------------
    // Drive output 1 stays zero: port 1 has no drive register.
    always_comb begin
        for (int p = 0; p < 7; p++) begin
            opendrain_select_bits_o[p] = regs_reg[p];
        end
        drive_strength_bits_o[0] = regs_reg[pfc_pkg::PFC_K_DS0];
        drive_strength_bits_o[1] = 8'h00;
        for (int p = 2; p < 8; p++) begin
            drive_strength_bits_o[p] =
                regs_reg[pfc_pkg::PFC_K_DS0 + p - 1];
        end
    end

    // ------------------------------------------------------------------
    // Pin routing with fixed priority
    // ------------------------------------------------------------------
    // Priority on shared pins: short timers first, then long timers, then
    // the clock output, matching the order of the pin selection tables.
    // A prohibited code 11 grants no pin at all, so nothing is driven.
    always_comb begin
        logic [7:0] stoe;
        logic [7:0] stsl;
        logic [7:0] ltoe;
        logic [7:0] ltsl;
        logic [7:0] ckr;
        stoe = regs_reg[pfc_pkg::PFC_K_STOE];
        stsl = regs_reg[pfc_pkg::PFC_K_STSL];
        ltoe = regs_reg[pfc_pkg::PFC_K_LTOE];
        ltsl = regs_reg[pfc_pkg::PFC_K_LTSL];
        ckr  = regs_reg[pfc_pkg::PFC_K_CLK];
        route_next.stm_a = stoe[5:0] & ~stsl[5:0];
        route_next.stm_b = stoe[5:0] &  stsl[5:0];
        for (int t = 0; t < 3; t++) begin
            route_next.ltm_a[t] = ltoe[t] &
                (ltsl[2*t +: 2] == pfc_pkg::PFC_PIN_FIRST);
            route_next.ltm_b[t] = ltoe[t] &
                (ltsl[2*t +: 2] == pfc_pkg::PFC_PIN_SECOND);
            route_next.ltm_c[t] = ltoe[t] &
                (ltsl[2*t +: 2] == pfc_pkg::PFC_PIN_THIRD);
        end
        route_next.clk_a = ckr[pfc_pkg::PFC_CLK_EN_BIT] &
                           ~ckr[pfc_pkg::PFC_CLK_PIN_BIT];
        route_next.clk_b = ckr[pfc_pkg::PFC_CLK_EN_BIT] &
                           ckr[pfc_pkg::PFC_CLK_PIN_BIT];
        // Shared pad between timer 0 first pin, timer 2 first pin, clock.
        route_next.stm_a[2] = route_next.stm_a[2] & ~route_next.stm_a[0];
        route_next.clk_a = route_next.clk_a & ~route_next.stm_a[0] &
                           ~route_next.stm_a[2];
        // Other shared pads: short timer beats long timer, timer beats clock.
        route_next.ltm_c[1] = route_next.ltm_c[1] & ~route_next.stm_b[2];
        route_next.ltm_c[0] = route_next.ltm_c[0] & ~route_next.stm_b[0];
        route_next.ltm_b[0] = route_next.ltm_b[0] & ~route_next.stm_a[4];
        route_next.ltm_b[2] = route_next.ltm_b[2] & ~route_next.stm_b[1];
        route_next.clk_b = route_next.clk_b & ~route_next.ltm_a[1];
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            route_reg <= '0;
        end else begin
            route_reg <= route_next;
        end
    end

    assign route_o = route_reg;

    // ------------------------------------------------------------------
    // Clock output source
    // ------------------------------------------------------------------
    // The chosen source is sampled at the clk_i rate, so a source faster
    // than half of it is aliased; that is the price of registered outputs.
    always_comb begin
        logic [7:0] ckr;
        ckr = regs_reg[pfc_pkg::PFC_K_CLK];
        case (pfc_pkg::pfc_clk_src_t'(ckr[pfc_pkg::PFC_CLK_SRC_LSB +: 2]))
            pfc_pkg::PFC_SRC_SUB:  clock_out_next = sub_clk_i;
            pfc_pkg::PFC_SRC_HS:   clock_out_next = hs_clk_i;
            pfc_pkg::PFC_SRC_SYS:  clock_out_next = system_clock_i;
            pfc_pkg::PFC_SRC_RTC:  clock_out_next = rtc_tb_clk_i;
            default:               clock_out_next = 1'b0;
        endcase
        if (!ckr[pfc_pkg::PFC_CLK_EN_BIT]) begin
            clock_out_next = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clock_out_reg <= 1'b0;
        end else begin
            clock_out_reg <= clock_out_next;
        end
    end

    assign clock_out_o = clock_out_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence apb_wait_s;
        psel_i & penable_i & ~pready_o;
    endsequence

    sequence apb_write_s;
        psel_i & penable_i & pready_o & pwrite_i & pstrb_i[0];
    endsequence

    apb_answer_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        apb_wait_s |=> pready_o)
        else $error("Access phase not answered in one cycle.");

    od_write_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (apb_write_s and (paddr_i[15:2] >= pfc_pkg::PFC_IDX_OD0) and
         (paddr_i[15:2] <= pfc_pkg::PFC_IDX_OD6) and (paddr_i[1:0] == 2'h0))
        |=> opendrain_select_bits_o[$past(paddr_i[4:2])] ==
            ($past(pwdata_i[7:0]) &
             pfc_pkg::PFC_MSK_TAB[$past(paddr_i[4:2])]))
        else $error("Open-drain write not stored through its mask.");

    od_pad_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (apb_write_s and (paddr_i == {pfc_pkg::PFC_IDX_OD3, 2'b00}))
        |=> opendrain_select_bits_o[3][0] == $past(pwdata_i[0]))
        else $error("Open-drain pad control does not follow its bit.");

    ds_absent_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        drive_strength_bits_o[1] == 8'h00 && !drive_strength_bits_o[2][7])
        else $error("Absent drive-strength bit is set.");

    stm_route_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (regs_reg[pfc_pkg::PFC_K_STOE][3] &&
         regs_reg[pfc_pkg::PFC_K_STSL][3])
        |=> route_o.stm_b[3] && !route_o.stm_a[3])
        else $error("Short timer 3 not routed to its second pin.");

    ltm_code_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (regs_reg[pfc_pkg::PFC_K_LTSL][5:4] == pfc_pkg::PFC_PIN_BAD)
        |=> !(route_o.ltm_a[2] | route_o.ltm_b[2] | route_o.ltm_c[2]))
        else $error("Prohibited long timer code granted a pin.");

    clk_src_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (regs_reg[pfc_pkg::PFC_K_CLK][3:0] == 4'h9)
        |=> clock_out_o == $past(system_clock_i))
        else $error("Clock output not following the system clock.");

    clk_off_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        !regs_reg[pfc_pkg::PFC_K_CLK][pfc_pkg::PFC_CLK_EN_BIT] [*2]
        |-> !route_o.clk_a && !route_o.clk_b && !clock_out_o)
        else $error("Clock output active while disabled.");

    pin_share_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        $onehot0({route_o.stm_a[0], route_o.stm_a[2], route_o.clk_a}) &&
        $onehot0({route_o.stm_b[2], route_o.ltm_c[1]}) &&
        $onehot0({route_o.stm_b[0], route_o.ltm_c[0]}) &&
        $onehot0({route_o.stm_a[4], route_o.ltm_b[0]}) &&
        $onehot0({route_o.stm_b[1], route_o.ltm_b[2]}) &&
        $onehot0({route_o.ltm_a[1], route_o.clk_b}))
        else $error("Two functions granted the same pin.");

endmodule : pfc_top

/* tb/pfc_clk_src.sv */
// ----------------------------------------------------------------------
// Clock sources seen by the clock output selector
// ----------------------------------------------------------------------
module pfc_clk_src (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    output logic      sub_clk_o,
    output logic      hs_clk_o,
    output logic      system_clock_o,
    output logic      rtc_tb_clk_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [15:0] tick_reg;

    // Each source toggles at its own slow rate, so a wrong selection shows.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_reg       <= 16'h0000;
            sub_clk_o      <= 1'b0;
            hs_clk_o       <= 1'b0;
            system_clock_o <= 1'b0;
            rtc_tb_clk_o   <= 1'b0;
        end else begin
            tick_reg <= tick_reg + 16'h0001;
            if (tick_reg % 20 == 0) sub_clk_o <= ~sub_clk_o;
            if (tick_reg % 6 == 0) hs_clk_o <= ~hs_clk_o;
            if (tick_reg % 10 == 0) system_clock_o <= ~system_clock_o;
            if (tick_reg % 14 == 0) rtc_tb_clk_o <= ~rtc_tb_clk_o;
        end
    end
endmodule : pfc_clk_src

/* tb/pfc_top_bench.sv */
module pfc_top_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic                clk;
    logic                rst_n;
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [15:0]         paddr;
    logic [31:0]         pwdata;
    logic [3:0]          pstrb;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic [3:0]          srcs;
    logic [6:0][7:0]     od_bits;
    logic [7:0][7:0]     ds_bits;
    pfc_pkg::pfc_route_t route;
    logic                clk_out;
    logic [31:0]         rd;
    logic                err;
    logic [1:0]          cc;
    int                  mismatches = 0;
    int                  check_count = 0;
    int                  cycles = 0;
    logic [7:0]          msk [19] = '{8'hB0, 8'h20, 8'h38, 8'hC7, 8'hDD,
        8'h1D, 8'hE0, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'h3F, 8'h3F, 8'h07, 8'h3F, 8'h0F};

    pfc_top i_dut (
        .clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .sub_clk_i(srcs[0]), .hs_clk_i(srcs[1]),
        .system_clock_i(srcs[2]), .rtc_tb_clk_i(srcs[3]),
        .opendrain_select_bits_o(od_bits), .drive_strength_bits_o(ds_bits),
        .route_o(route), .clock_out_o(clk_out));

    pfc_clk_src i_src (
        .clk_i(clk), .rst_n_i(rst_n), .sub_clk_o(srcs[0]),
        .hs_clk_o(srcs[1]), .system_clock_o(srcs[2]),
        .rtc_tb_clk_o(srcs[3]));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task close_out;
        $display("Checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out

    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Ready is sampled at the rising edge itself; the write lands and the
    // read data is taken at that same edge, and only then is the request
    // released, so no wait count is assumed.
    task apb(input logic w, input logic [13:0] idx, input logic [7:0] d,
             input logic [3:0] s);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h00_0000, d};
        pstrb   <= s;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            mismatches++;
            close_out();
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task settle;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task clk_case(input logic [1:0] src, input logic sel, input logic en);
        logic [3:0] h;
        apb(1'b1, pfc_pkg::PFC_IDX_CLK, {4'h0, src, sel, en}, 4'h1);
        settle();
        check(route.clk_a, en & ~sel);
        check(route.clk_b, en & sel);
        // The seed pattern cannot look settled until three real samples agree.
        h = 4'h5;
        for (int n = 0; n < 60; n++) begin
            @(negedge clk);
            h = {h[2:0], srcs[src]};
            if (!en || h == 4'h0 || h == 4'hF) check(clk_out, en & h[0]);
        end
    endtask : clk_case

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            mismatches++;
            close_out();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int k = 0; k < 19; k++) begin
            apb(1'b0, pfc_pkg::PFC_IDX_TAB[k], 8'h00, 4'h0);
            check(rd, 32'h0000_0000);
            check(err, 1'b0);
        end
        for (int k = 0; k < 19; k++) begin
            apb(1'b1, pfc_pkg::PFC_IDX_TAB[k], 8'hFF, 4'h1);
            apb(1'b0, pfc_pkg::PFC_IDX_TAB[k], 8'h00, 4'h0);
            check(rd, {24'h00_0000, msk[k]});
            if (k < 7) check(od_bits[k], msk[k]);
            else if (k < 14) check(ds_bits[k == 7 ? 0 : k - 6], msk[k]);
            if (k == 8) check(ds_bits[1], 8'h00);
            apb(1'b1, pfc_pkg::PFC_IDX_TAB[k], 8'h00, 4'h1);
            apb(1'b0, pfc_pkg::PFC_IDX_TAB[k], 8'h00, 4'h0);
            check(rd, 32'h0000_0000);
        end
        apb(1'b1, pfc_pkg::PFC_IDX_OD3, 8'hFF, 4'h0);
        apb(1'b0, pfc_pkg::PFC_IDX_OD3, 8'h00, 4'h0);
        check(rd, 32'h0000_0000);
        apb(1'b1, 14'h3F57, 8'hFF, 4'h1);
        check(err, 1'b1);
        apb(1'b0, 14'h3F57, 8'h00, 4'h0);
        check(err, 1'b1);
        check(rd, 32'h0000_0000);
        // A reset in mid-run must clear what software left behind.
        apb(1'b1, pfc_pkg::PFC_IDX_OD0, 8'hFF, 4'h1);
        @(posedge clk);
        check(od_bits[0], 8'hB0);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        check(od_bits[0], 8'h00);
        apb(1'b0, pfc_pkg::PFC_IDX_OD0, 8'h00, 4'h0);
        check(rd, 32'h0000_0000);
        for (int i = 0; i < 6; i++) begin
            for (int s = 0; s < 2; s++) begin
                apb(1'b1, pfc_pkg::PFC_IDX_STOE, 8'(1 << i), 4'h1);
                apb(1'b1, pfc_pkg::PFC_IDX_STSL, s ? 8'(1 << i) : 8'h00, 4'h1);
                settle();
                check(route.stm_a, s ? 6'h00 : 6'(1 << i));
                check(route.stm_b, s ? 6'(1 << i) : 6'h00);
            end
        end
        apb(1'b1, pfc_pkg::PFC_IDX_STSL, 8'h00, 4'h1);
        apb(1'b1, pfc_pkg::PFC_IDX_STOE, 8'h05, 4'h1);
        apb(1'b1, pfc_pkg::PFC_IDX_CLK, 8'h01, 4'h1);
        settle();
        check(route.stm_a, 6'h01);
        check(route.clk_a, 1'b0);
        apb(1'b1, pfc_pkg::PFC_IDX_STOE, 8'h00, 4'h1);
        apb(1'b1, pfc_pkg::PFC_IDX_LTOE, 8'h07, 4'h1);
        for (int c = 0; c < 4; c++) begin
            cc = 2'(c);
            apb(1'b1, pfc_pkg::PFC_IDX_LTSL, {2'b00, cc, cc, cc}, 4'h1);
            settle();
            check(route.ltm_a, c == 0 ? 3'h7 : 3'h0);
            check(route.ltm_b, c == 1 ? 3'h7 : 3'h0);
            check(route.ltm_c, c == 2 ? 3'h7 : 3'h0);
        end
        apb(1'b1, pfc_pkg::PFC_IDX_LTSL, 8'h00, 4'h1);
        apb(1'b1, pfc_pkg::PFC_IDX_LTOE, 8'h00, 4'h1);
        for (int c = 0; c < 4; c++) begin
            for (int s = 0; s < 2; s++) clk_case(2'(c), s[0], 1'b1);
        end
        clk_case(2'b10, 1'b0, 1'b0);
        close_out();
    end
endmodule : pfc_top_bench
